// ---- common/mlt_pkg.sv ----
package mlt_pkg;

  // machine cycle clock counter width
  localparam int MCYC_CNT_W = 4;

  // instruction byte lengths and machine cycle counts
  localparam logic [1:0] BYTES_1 = 2'h1;
  localparam logic [1:0] BYTES_2 = 2'h2;
  localparam logic [1:0] BYTES_3 = 2'h3;
  localparam logic [1:0] CYC_1   = 2'h1;
  localparam logic [1:0] CYC_2   = 2'h2;

  // opcode upper nibble groups
  localparam logic [3:0] HI_ROR   = 4'h0;
  localparam logic [3:0] HI_RORC  = 4'h1;
  localparam logic [3:0] HI_ROL   = 4'h2;
  localparam logic [3:0] HI_ROLC  = 4'h3;
  localparam logic [3:0] HI_OR    = 4'h4;
  localparam logic [3:0] HI_AND   = 4'h5;
  localparam logic [3:0] HI_XOR   = 4'h6;
  localparam logic [3:0] HI_IMM   = 4'h7;
  localparam logic [3:0] HI_TODIR = 4'h8;
  localparam logic [3:0] HI_PTR   = 4'h9;
  localparam logic [3:0] HI_FROMD = 4'hA;
  localparam logic [3:0] HI_NBITA = 4'hB;
  localparam logic [3:0] HI_XCH   = 4'hC;
  localparam logic [3:0] HI_POP   = 4'hD;
  localparam logic [3:0] HI_TOA   = 4'hE;
  localparam logic [3:0] HI_FROMA = 4'hF;

  // opcode lower nibble forms
  localparam logic [3:0] LO_X0    = 4'h0;
  localparam logic [3:0] LO_DIR_A = 4'h2;
  localparam logic [3:0] LO_DIR_I = 4'h3;
  localparam logic [3:0] LO_IMM   = 4'h4;
  localparam logic [3:0] LO_DIR   = 4'h5;
  localparam logic [2:0] LO_IND   = 3'h3;
  localparam int         LO_RN_B  = 3;

  // direct address of the accumulator itself
  localparam logic [7:0] ACCUMULATOR_DIRECT_ADDRESS = 8'hE0;

  typedef enum logic [4:0] {
    OP_NONE, LOGICAL_AND_OP, LOGICAL_OR_OP, LOGICAL_XOR_OP, OP_CLEAR,
    COMPLEMENT_OP, ROTATE_LEFT_OP, ROTATE_LEFT_CARRY_OP, ROTATE_RIGHT_OP,
    ROTATE_RIGHT_CARRY_OP, OP_SWAP, MOVE_OP, CODE_READ_OP,
    EXTERNAL_RAM_MOVE_OP, OP_PUSH, OP_POP, OP_EXCHANGE,
    LOW_NIBBLE_EXCHANGE_OP, BIT_SET_OP, OP_AND_NOT, OP_OR_NOT
  } mlt_op_e;

  typedef enum logic [3:0] {
    OPD_NONE, OPD_ACCUM, OPD_WREG, OPD_IND, OPD_DIR, OPD_IMM, OPD_IMM16,
    OPD_CARRY, OPD_BIT, OPD_DP, OPD_CODE_DP, OPD_CODE_PC, OPD_XRAM8,
    OPD_XRAM16, OPD_STACK
  } mlt_opnd_e;

  typedef struct packed {
    mlt_op_e   op;
    mlt_opnd_e dst;
    mlt_opnd_e src;
    logic [1:0] len;
    logic [1:0] cyc;
    logic       known;
  } mlt_dec_s;

  typedef struct packed {
    mlt_dec_s              dec;
    logic [1:0]            mcyc;
    logic [MCYC_CNT_W-1:0] clk_cnt;
    logic [1:0]            byte_idx;
    logic                  busy;
    logic                  ready;
    logic                  fetch;
    logic                  done;
    logic                  invalid;
  } mlt_state_s;

  localparam mlt_state_s ST_RST = '{
    dec: '{op: OP_NONE, dst: OPD_NONE, src: OPD_NONE,
           len: BYTES_1, cyc: CYC_1, known: 1'b0},
    mcyc: 2'h0, clk_cnt: '0, byte_idx: 2'h0, busy: 1'b0, ready: 1'b1,
    fetch: 1'b0, done: 1'b0, invalid: 1'b0};

endpackage

// ---- logic/mlt_decoder.sv ----
`timescale 1ns/1ps
module mlt_decoder #(
  parameter int MCYC_CLKS = 1
) (
  // clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               srst_i,
  // opcode stream
  input  wire logic [7:0]         opcode_i,
  input  wire logic               opcode_valid_i,
  input  wire logic [7:0]         operand_i,
  input  wire logic               operand_valid_i,
  // decode results
  output logic                    ready_o,
  output logic                    busy_o,
  output mlt_pkg::mlt_op_e        op_o,
  output mlt_pkg::mlt_opnd_e      dst_o,
  output mlt_pkg::mlt_opnd_e      src_o,
  output logic [1:0]              len_o,
  output logic [1:0]              cycles_o,
  output logic                    known_o,
  // sequencing
  output logic [1:0]              mcycle_o,
  output logic                    fetch_req_o,
  output logic                    done_o,
  output logic                    invalid_o
);
  import mlt_pkg::*;

  // every check in this module runs on the core clock, off during reset
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);

  localparam logic [MCYC_CNT_W-1:0] MCYC_LAST = MCYC_CNT_W'(MCYC_CLKS - 1);

  // counter width bounds the machine cycle length
  if (MCYC_CLKS < 1 || MCYC_CLKS > (1 << MCYC_CNT_W)) begin : g_bad_mcyc
    $error("MCYC_CLKS out of range");
  end

  mlt_state_s st_ff;
  mlt_state_s nxt_st;

  function automatic mlt_dec_s mk(mlt_op_e op, mlt_opnd_e d, mlt_opnd_e s,
                                  logic [1:0] l, logic [1:0] c);
    mlt_dec_s r;
    r.op    = op;
    r.dst   = d;
    r.src   = s;
    r.len   = l;
    r.cyc   = c;
    r.known = 1'b1;
    return r;
  endfunction

  // opcodes matching none of these forms decode as unknown, one byte, one cycle
  function automatic mlt_dec_s mlt_decode(logic [7:0] opc);
    logic [3:0] hi;
    logic [3:0] lo;
    logic       rn;
    logic       ind;
    mlt_opnd_e  reg_src;
    mlt_op_e    lop;
    mlt_dec_s   r;
    hi  = opc[7:4];
    lo  = opc[3:0];
    rn  = opc[LO_RN_B];
    ind = (opc[3:1] == LO_IND);
    reg_src = rn ? OPD_WREG : OPD_IND;
    lop = (hi == HI_AND) ? LOGICAL_AND_OP :
          (hi == HI_OR)  ? LOGICAL_OR_OP  : LOGICAL_XOR_OP;
    r = ST_RST.dec;
    unique case (hi)
      HI_AND, HI_OR, HI_XOR: begin
        if (rn || ind) begin
          r = mk(lop, OPD_ACCUM, reg_src, BYTES_1, CYC_1);
        end else if (lo == LO_DIR) begin
          r = mk(lop, OPD_ACCUM, OPD_DIR, BYTES_2, CYC_1);
        end else if (lo == LO_IMM) begin
          r = mk(lop, OPD_ACCUM, OPD_IMM, BYTES_2, CYC_1);
        end else if (lo == LO_DIR_A) begin
          r = mk(lop, OPD_DIR, OPD_ACCUM, BYTES_2, CYC_1);
        end else if (lo == LO_DIR_I) begin
          r = mk(lop, OPD_DIR, OPD_IMM, BYTES_3, CYC_2);
        end
      end
      HI_ROR, HI_RORC, HI_ROL, HI_ROLC: begin
        if (lo == LO_DIR_I) begin
          r = mk(hi == HI_ROR  ? ROTATE_RIGHT_OP :
                 hi == HI_RORC ? ROTATE_RIGHT_CARRY_OP :
                 hi == HI_ROL  ? ROTATE_LEFT_OP : ROTATE_LEFT_CARRY_OP,
                 OPD_ACCUM, OPD_ACCUM, BYTES_1, CYC_1);
        end
      end
      HI_TOA: begin
        if (rn || ind) begin
          r = mk(MOVE_OP, OPD_ACCUM, reg_src, BYTES_1, CYC_1);
        end else if (lo == LO_DIR) begin
          r = mk(MOVE_OP, OPD_ACCUM, OPD_DIR, BYTES_2, CYC_1);
        end else if (lo == LO_IMM) begin
          r = mk(OP_CLEAR, OPD_ACCUM, OPD_NONE, BYTES_1, CYC_1);
        end else if (lo == LO_X0) begin
          r = mk(EXTERNAL_RAM_MOVE_OP, OPD_ACCUM, OPD_XRAM16,
                 BYTES_1, CYC_2);
        end else if (lo == LO_DIR_A || lo == LO_DIR_I) begin
          r = mk(EXTERNAL_RAM_MOVE_OP, OPD_ACCUM, OPD_XRAM8,
                 BYTES_1, CYC_2);
        end
      end
      HI_FROMA: begin
        if (rn || ind) begin
          r = mk(MOVE_OP, reg_src, OPD_ACCUM, BYTES_1, CYC_1);
        end else if (lo == LO_DIR) begin
          r = mk(MOVE_OP, OPD_DIR, OPD_ACCUM, BYTES_2, CYC_1);
        end else if (lo == LO_IMM) begin
          r = mk(COMPLEMENT_OP, OPD_ACCUM, OPD_ACCUM, BYTES_1, CYC_1);
        end else if (lo == LO_X0) begin
          r = mk(EXTERNAL_RAM_MOVE_OP, OPD_XRAM16, OPD_ACCUM,
                 BYTES_1, CYC_2);
        end else if (lo == LO_DIR_A || lo == LO_DIR_I) begin
          r = mk(EXTERNAL_RAM_MOVE_OP, OPD_XRAM8, OPD_ACCUM,
                 BYTES_1, CYC_2);
        end
      end
      HI_IMM: begin
        if (rn || ind) begin
          r = mk(MOVE_OP, reg_src, OPD_IMM, BYTES_2, CYC_1);
        end else if (lo == LO_IMM) begin
          r = mk(MOVE_OP, OPD_ACCUM, OPD_IMM, BYTES_2, CYC_1);
        end else if (lo == LO_DIR) begin
          r = mk(MOVE_OP, OPD_DIR, OPD_IMM, BYTES_3, CYC_2);
        end else if (lo == LO_DIR_A) begin
          r = mk(LOGICAL_OR_OP, OPD_CARRY, OPD_BIT, BYTES_2, CYC_2);
        end
      end
      HI_FROMD: begin
        if (rn || ind) begin
          r = mk(MOVE_OP, reg_src, OPD_DIR, BYTES_2, CYC_2);
        end else if (lo == LO_X0) begin
          r = mk(OP_OR_NOT, OPD_CARRY, OPD_BIT, BYTES_2, CYC_2);
        end else if (lo == LO_DIR_A) begin
          r = mk(MOVE_OP, OPD_CARRY, OPD_BIT, BYTES_2, CYC_1);
        end
      end
      HI_TODIR: begin
        if (rn || ind) begin
          r = mk(MOVE_OP, OPD_DIR, reg_src, BYTES_2, CYC_2);
        end else if (lo == LO_DIR) begin
          r = mk(MOVE_OP, OPD_DIR, OPD_DIR, BYTES_3, CYC_2);
        end else if (lo == LO_DIR_A) begin
          r = mk(LOGICAL_AND_OP, OPD_CARRY, OPD_BIT, BYTES_2, CYC_2);
        end else if (lo == LO_DIR_I) begin
          r = mk(CODE_READ_OP, OPD_ACCUM, OPD_CODE_PC, BYTES_1, CYC_2);
        end
      end
      HI_PTR: begin
        if (lo == LO_X0) begin
          r = mk(MOVE_OP, OPD_DP, OPD_IMM16, BYTES_3, CYC_2);
        end else if (lo == LO_DIR_A) begin
          r = mk(MOVE_OP, OPD_BIT, OPD_CARRY, BYTES_2, CYC_2);
        end else if (lo == LO_DIR_I) begin
          r = mk(CODE_READ_OP, OPD_ACCUM, OPD_CODE_DP, BYTES_1, CYC_2);
        end
      end
      HI_NBITA: begin
        if (lo == LO_X0) begin
          r = mk(OP_AND_NOT, OPD_CARRY, OPD_BIT, BYTES_2, CYC_2);
        end else if (lo == LO_DIR_A) begin
          r = mk(COMPLEMENT_OP, OPD_BIT, OPD_BIT, BYTES_2, CYC_1);
        end else if (lo == LO_DIR_I) begin
          r = mk(COMPLEMENT_OP, OPD_CARRY, OPD_CARRY, BYTES_1, CYC_1);
        end
      end
      HI_XCH: begin
        if (rn || ind) begin
          r = mk(OP_EXCHANGE, OPD_ACCUM, reg_src, BYTES_1, CYC_1);
        end else if (lo == LO_DIR) begin
          r = mk(OP_EXCHANGE, OPD_ACCUM, OPD_DIR, BYTES_2, CYC_1);
        end else if (lo == LO_IMM) begin
          r = mk(OP_SWAP, OPD_ACCUM, OPD_ACCUM, BYTES_1, CYC_1);
        end else if (lo == LO_X0) begin
          r = mk(OP_PUSH, OPD_STACK, OPD_DIR, BYTES_2, CYC_2);
        end else if (lo == LO_DIR_A) begin
          r = mk(OP_CLEAR, OPD_BIT, OPD_NONE, BYTES_2, CYC_1);
        end else if (lo == LO_DIR_I) begin
          r = mk(OP_CLEAR, OPD_CARRY, OPD_NONE, BYTES_1, CYC_1);
        end
      end
      HI_POP: begin
        if (ind) begin
          r = mk(LOW_NIBBLE_EXCHANGE_OP, OPD_ACCUM, OPD_IND,
                 BYTES_1, CYC_1);
        end else if (lo == LO_X0) begin
          r = mk(OP_POP, OPD_DIR, OPD_STACK, BYTES_2, CYC_2);
        end else if (lo == LO_DIR_A) begin
          r = mk(BIT_SET_OP, OPD_BIT, OPD_NONE, BYTES_2, CYC_1);
        end else if (lo == LO_DIR_I) begin
          r = mk(BIT_SET_OP, OPD_CARRY, OPD_NONE, BYTES_1, CYC_1);
        end
      end
    endcase
    return r;
  endfunction

  // sequencer: one operand byte fetched at the start of each machine cycle while byte_idx is below len
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.fetch = 1'b0;
    nxt_st.done  = 1'b0;
    if (st_ff.busy) begin
      if (st_ff.clk_cnt == MCYC_LAST) begin
        nxt_st.clk_cnt = '0;
        if (st_ff.mcyc == st_ff.dec.cyc - CYC_1) begin
          nxt_st.busy  = 1'b0;
          nxt_st.ready = 1'b1;
          nxt_st.done  = 1'b1;
        end else begin
          nxt_st.mcyc = st_ff.mcyc + 2'h1;
          if (st_ff.byte_idx < st_ff.dec.len) begin
            nxt_st.fetch    = 1'b1;
            nxt_st.byte_idx = st_ff.byte_idx + 2'h1;
          end
        end
      end else begin
        nxt_st.clk_cnt = st_ff.clk_cnt + MCYC_CNT_W'(1);
      end
      // accumulator as its own direct source is flagged; the instruction still runs its machine cycles to done
      if (operand_valid_i && st_ff.dec.op == MOVE_OP &&
          st_ff.dec.dst == OPD_ACCUM && st_ff.dec.src == OPD_DIR &&
          operand_i == ACCUMULATOR_DIRECT_ADDRESS) begin
        nxt_st.invalid = 1'b1;
      end
    end else if (opcode_valid_i) begin
      nxt_st.dec      = mlt_decode(opcode_i);
      nxt_st.busy     = 1'b1;
      nxt_st.ready    = 1'b0;
      nxt_st.mcyc     = 2'h0;
      nxt_st.clk_cnt  = '0;
      nxt_st.invalid  = 1'b0;
      nxt_st.fetch    = (nxt_st.dec.len > BYTES_1);
      nxt_st.byte_idx = nxt_st.fetch ? BYTES_2 : BYTES_1;
    end
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state flops
  assign ready_o     = st_ff.ready;
  assign busy_o      = st_ff.busy;
  assign op_o        = st_ff.dec.op;
  assign dst_o       = st_ff.dec.dst;
  assign src_o       = st_ff.dec.src;
  assign len_o       = st_ff.dec.len;
  assign cycles_o    = st_ff.dec.cyc;
  assign known_o     = st_ff.dec.known;
  assign mcycle_o    = st_ff.mcyc;
  assign fetch_req_o = st_ff.fetch;
  assign done_o      = st_ff.done;
  assign invalid_o   = st_ff.invalid;

  // helper counters for the checks below
  logic [7:0] chk_clks_ff;
  logic [1:0] chk_bytes_ff;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !st_ff.busy) begin
      chk_clks_ff  <= 8'h0;
      chk_bytes_ff <= BYTES_1;
    end else begin
      chk_clks_ff  <= chk_clks_ff + 8'h1;
      chk_bytes_ff <= chk_bytes_ff + 2'(st_ff.fetch);
    end
  end

  logic take;
  assign take = opcode_valid_i && st_ff.ready;

  a_logic_reg_src: assert property (take &&
    opcode_i[7:4] == HI_AND && opcode_i[3] |=> op_o == LOGICAL_AND_OP &&
    src_o == OPD_WREG && len_o == BYTES_1 && cycles_o == CYC_1)
    else $error("logic register form wrong");
  a_logic_to_dir: assert property (take &&
    opcode_i == {HI_OR, LO_DIR_A} |=> dst_o == OPD_DIR && len_o == BYTES_2 &&
    cycles_o == CYC_1) else $error("logic to direct form wrong");
  a_logic_imm_dir: assert property (take &&
    opcode_i == {HI_XOR, LO_DIR_I} |=> len_o == BYTES_3 &&
    cycles_o == CYC_2 && src_o == OPD_IMM)
    else $error("logic immediate to direct wrong");
  a_acc_unary: assert property (busy_o && dst_o == OPD_ACCUM &&
    op_o inside {OP_CLEAR, COMPLEMENT_OP, ROTATE_LEFT_OP, ROTATE_RIGHT_OP,
    ROTATE_LEFT_CARRY_OP, ROTATE_RIGHT_CARRY_OP, OP_SWAP} |-> len_o == BYTES_1
    && cycles_o == CYC_1) else $error("accumulator unary length wrong");
  a_load_acc: assert property (busy_o && op_o == MOVE_OP &&
    dst_o == OPD_ACCUM |-> cycles_o == CYC_1 &&
    len_o == ((src_o inside {OPD_DIR, OPD_IMM}) ? BYTES_2 : BYTES_1))
    else $error("accumulator load length wrong");
  a_load_wreg: assert property (busy_o && op_o == MOVE_OP &&
    dst_o inside {OPD_WREG, OPD_IND} |->
    cycles_o == ((src_o == OPD_DIR) ? CYC_2 : CYC_1))
    else $error("register or indirect load cycles wrong");
  a_write_dir: assert property (busy_o && op_o == MOVE_OP &&
    dst_o == OPD_DIR |-> (src_o == OPD_ACCUM) == (cycles_o == CYC_1) &&
    (src_o inside {OPD_DIR, OPD_IMM}) == (len_o == BYTES_3))
    else $error("direct write length wrong");
  a_long_forms: assert property (busy_o &&
    op_o inside {CODE_READ_OP, EXTERNAL_RAM_MOVE_OP} |->
    len_o == BYTES_1 && cycles_o == CYC_2)
    else $error("code or external move length wrong");
  a_pointer_load: assert property (take &&
    opcode_i == {HI_PTR, LO_X0} |=> dst_o == OPD_DP && len_o == BYTES_3 &&
    cycles_o == CYC_2 && fetch_req_o ##MCYC_CLKS
    fetch_req_o && mcycle_o == 2'h1) else $error("pointer load fetch wrong");
  a_stack_ops: assert property (busy_o &&
    op_o inside {OP_PUSH, OP_POP} |-> len_o == BYTES_2 && cycles_o == CYC_2)
    else $error("stack op length wrong");
  a_exchange: assert property (busy_o &&
    op_o inside {OP_EXCHANGE, LOW_NIBBLE_EXCHANGE_OP} |->
    cycles_o == CYC_1 && (len_o == BYTES_2) == (src_o == OPD_DIR))
    else $error("exchange length wrong");
  a_carry_bit: assert property (busy_o &&
    dst_o == OPD_CARRY && src_o == OPD_BIT |-> len_o == BYTES_2 &&
    cycles_o == ((op_o == MOVE_OP) ? CYC_1 : CYC_2))
    else $error("carry bit form wrong");
  a_bit_write: assert property (busy_o && dst_o == OPD_BIT |->
    len_o == BYTES_2 && cycles_o == ((src_o == OPD_CARRY) ? CYC_2 : CYC_1))
    else $error("bit write form wrong");
  a_self_load: assert property (busy_o && op_o == MOVE_OP &&
    dst_o == OPD_ACCUM && src_o == OPD_DIR && operand_valid_i &&
    operand_i == ACCUMULATOR_DIRECT_ADDRESS |=> invalid_o)
    else $error("self load not flagged");
  a_done_timing: assert property (done_o |->
    8'(chk_clks_ff) == 8'($past(cycles_o)) * 8'(MCYC_CLKS) &&
    $past(chk_bytes_ff) == $past(len_o))
    else $error("instruction length or cycles not kept");

endmodule

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import mlt_pkg::*;

  // two clocks per machine cycle so the count scaling is exercised
  localparam int MC = 2;

  logic             clk_sys_i       = 1'b0;
  logic             srst_i          = 1'b1;
  logic [7:0]       opcode_i        = 8'h00;
  logic             opcode_valid_i  = 1'b0;
  logic [7:0]       operand_i       = 8'h00;
  logic             operand_valid_i = 1'b0;
  logic             ready_o;
  logic             busy_o;
  mlt_op_e          op_o;
  mlt_opnd_e        dst_o;
  mlt_opnd_e        src_o;
  logic [1:0]       len_o;
  logic [1:0]       cycles_o;
  logic             known_o;
  logic [1:0]       mcycle_o;
  logic             fetch_req_o;
  logic             done_o;
  logic             invalid_o;
  int               failures        = 0;
  int               total_checks    = 0;
  int               seed            = 27;
  int               cyc_cnt         = 0;

  mlt_decoder #(.MCYC_CLKS(MC)) u_mlt_decoder (
    .clk_sys_i       (clk_sys_i),
    .srst_i          (srst_i),
    .opcode_i        (opcode_i),
    .opcode_valid_i  (opcode_valid_i),
    .operand_i       (operand_i),
    .operand_valid_i (operand_valid_i),
    .ready_o         (ready_o),
    .busy_o          (busy_o),
    .op_o            (op_o),
    .dst_o           (dst_o),
    .src_o           (src_o),
    .len_o           (len_o),
    .cycles_o        (cycles_o),
    .known_o         (known_o),
    .mcycle_o        (mcycle_o),
    .fetch_req_o     (fetch_req_o),
    .done_o          (done_o),
    .invalid_o       (invalid_o)
  );

  // free running core clock, 25 ns period
  always #12.5 clk_sys_i = ~clk_sys_i;

  // hang guard: whole run needs under two thousand clocks
  always @(posedge clk_sys_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      failures = failures + 1;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // reference length table: known flag, bytes, machine cycles
  function automatic void model(input logic [7:0] o, output int k,
                                output int l, output int c);
    k = 1;
    l = 1;
    c = 1;
    if (o inside {8'h42, 8'h44, 8'h45, 8'h52, 8'h54, 8'h55, 8'h62,
                  8'h64, 8'h65, 8'hE5, 8'h74, [8'h78:8'h7F], 8'hF5,
                  8'h76, 8'h77, 8'hC5, 8'hC2, 8'hD2, 8'hB2, 8'hA2})
      l = 2;
    else if (o inside {8'h43, 8'h53, 8'h63, 8'h85, 8'h75, 8'h90}) begin
      l = 3;
      c = 2;
    end else if (o inside {[8'hA8:8'hAF], [8'h86:8'h8F], 8'hA6, 8'hA7,
                           8'hC0, 8'hD0, 8'h82, 8'hB0, 8'h72, 8'hA0,
                           8'h92}) begin
      l = 2;
      c = 2;
    end else if (o inside {8'h93, 8'h83, 8'hE0, 8'hE2, 8'hE3, 8'hF0,
                           8'hF2, 8'hF3})
      c = 2;
    else if (!(o inside {[8'h46:8'h4F], [8'h56:8'h5F], [8'h66:8'h6F],
                         8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'h13,
                         8'hC4, [8'hE6:8'hEF], [8'hF8:8'hFF], 8'hF6,
                         8'hF7, [8'hC6:8'hCF], 8'hD6, 8'hD7, 8'hC3,
                         8'hD3, 8'hB3}))
      k = 0;
  endfunction

  task automatic chk_reset();
    chk("rst_ready", 8'(ready_o), 8'h01);
    chk("rst_busy", 8'(busy_o), 8'h00);
    chk("rst_op", 8'(op_o), 8'(OP_NONE));
    chk("rst_dst", 8'(dst_o), 8'(OPD_NONE));
    chk("rst_src", 8'(src_o), 8'(OPD_NONE));
    chk("rst_len", 8'(len_o), 8'h01);
    chk("rst_cycles", 8'(cycles_o), 8'h01);
    chk("rst_known", 8'(known_o), 8'h00);
    chk("rst_mcycle", 8'(mcycle_o), 8'h00);
    chk("rst_fetch", 8'(fetch_req_o), 8'h00);
    chk("rst_done", 8'(done_o), 8'h00);
    chk("rst_invalid", 8'(invalid_o), 8'h00);
  endtask

  // one instruction; returns one ns after the clock showing done
  task automatic run_op(input logic [7:0] op);
    int         k;
    int         l;
    int         c;
    int         n;
    int         f;
    logic [7:0] opd;
    logic       bad;
    model(op, k, l, c);
    opd = 8'($random(seed));
    if (op == 8'hE5 && opd[0])
      opd = ACCUMULATOR_DIRECT_ADDRESS;
    bad = (op == 8'hE5) && (opd == 8'hE0);
    opcode_i = op;
    opcode_valid_i = 1'b1;
    operand_i = opd;
    operand_valid_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    // a different opcode stays offered while busy and must be ignored
    opcode_i = ~op;
    n = 1;
    f = 0;
    chk("busy", 8'(busy_o), 8'h01);
    chk("known", 8'(known_o), 8'(k));
    chk("len", 8'(len_o), 8'(l));
    chk("cycles", 8'(cycles_o), 8'(c));
    chk("invalid_take", 8'(invalid_o), 8'h00);
    while (done_o !== 1'b1 && n < 40) begin
      if (fetch_req_o === 1'b1)
        f = f + 1;
      chk("mcycle", 8'(mcycle_o), 8'((n - 1) / MC));
      chk("len_hold", 8'(len_o), 8'(l));
      @(posedge clk_sys_i);
      #1;
      n = n + 1;
    end
    chk("done_time", 8'(n), 8'(c * MC + 1));
    chk("fetches", 8'(f), 8'(l - 1));
    chk("ready", 8'(ready_o), 8'h01);
    chk("invalid", 8'(invalid_o), 8'(bad));
  endtask

  task automatic go_idle();
    opcode_valid_i = 1'b0;
    operand_valid_i = 1'b0;
  endtask

  // main sequence: sweeps are back to back, next opcode in the done clock
  initial begin
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk_reset();
    srst_i = 1'b0;
    for (int i = 0; i < 256; i++)
      run_op(8'(i));
    go_idle();
    $display("test opcode_sweep done");
    repeat (150) run_op(8'($random(seed)));
    go_idle();
    $display("test random_stream done");
    repeat (12) run_op(8'hE5);
    run_op(8'hE8);
    go_idle();
    $display("test self_load done");
    @(posedge clk_sys_i);
    #1;
    opcode_i = 8'h53;
    opcode_valid_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    opcode_valid_i = 1'b0;
    srst_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk_reset();
    srst_i = 1'b0;
    run_op(8'h85);
    go_idle();
    $display("test mid_reset done");
    complete_run();
  end
endmodule
